// >>> hdl/stack_marker_pkg.sv
package stack_marker_pkg;
    localparam int ADDR_WIDTH = 16;
    localparam int DATA_WIDTH = 16;
    localparam int DIRECT_OFFSET_WIDTH = 8;
    localparam int MAX_CACHED = 4;
    localparam int COUNT_WIDTH = 3;
    localparam int MARKER_WORDS = 4;
    localparam logic [1:0] SLOT_INDEX = 2'h0;
    localparam logic [1:0] SLOT_RETURN = 2'h1;
    localparam logic [1:0] SLOT_STATUS = 2'h2;
    localparam logic [1:0] SLOT_DELTA = 2'h3;
    localparam logic [2:0] COUNT_RESET = 3'h0;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_FLUSH = 3'b001,
        ST_CALL = 3'b010,
        ST_EXIT_READ = 3'b011,
        ST_EXIT_TAKE = 3'b100,
        ST_GLOBAL = 3'b101
    } state_e;
endpackage

// >>> hdl/procedure_stack_marker.sv
`timescale 1ns/10ps
`default_nettype none
module procedure_stack_marker #(
    parameter int ADDR_W = stack_marker_pkg::ADDR_WIDTH,
    parameter int DATA_W = stack_marker_pkg::DATA_WIDTH
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic frame_load,
    input wire logic [ADDR_W-1:0] frame_load_value,
    input wire logic [ADDR_W-1:0] data_base_pointer,
    input wire logic [ADDR_W-1:0] stack_limit,
    input wire logic [ADDR_W-1:0] code_base,
    input wire logic [ADDR_W-1:0] program_counter,
    input wire logic [DATA_W-1:0] index_reg,
    input wire logic [DATA_W-1:0] status_word,
    input wire logic push_req,
    input wire logic [DATA_W-1:0] push_data,
    input wire logic procedure_call,
    input wire logic procedure_exit,
    input wire logic [ADDR_W-1:0] exit_discard,
    input wire logic global_rd_req,
    input wire logic [stack_marker_pkg::DIRECT_OFFSET_WIDTH-1:0] global_offset,
    input wire logic [DATA_W-1:0] mem_rdata,
    output logic mem_wr,
    output logic mem_rd,
    output logic [ADDR_W-1:0] mem_addr,
    output logic [DATA_W-1:0] mem_wdata,
    output logic [ADDR_W-1:0] frame_pointer,
    output logic [ADDR_W-1:0] memory_stack_top,
    output logic [stack_marker_pkg::COUNT_WIDTH-1:0] cached_word_count,
    output logic [ADDR_W-1:0] stack_top,
    output logic busy,
    output logic done,
    output logic overflow_int,
    output logic restore_valid,
    output logic [DATA_W-1:0] restored_index,
    output logic [ADDR_W-1:0] restored_pc,
    output logic [DATA_W-1:0] restored_status,
    output logic global_valid,
    output logic [DATA_W-1:0] global_data
);
    typedef struct packed {
        stack_marker_pkg::state_e state;
        logic [1:0] step;
        logic [stack_marker_pkg::COUNT_WIDTH-1:0] count;
        logic [stack_marker_pkg::MAX_CACHED-1:0][DATA_W-1:0] cache;
        logic [ADDR_W-1:0] smt;
        logic [ADDR_W-1:0] fp;
        logic [ADDR_W-1:0] base;
        logic [ADDR_W-1:0] discard;
        logic [ADDR_W-1:0] top;
        logic mem_wr;
        logic mem_rd;
        logic [ADDR_W-1:0] mem_addr;
        logic [DATA_W-1:0] mem_wdata;
        logic busy;
        logic done;
        logic overflow;
        logic restore_valid;
        logic [DATA_W-1:0] r_index;
        logic [ADDR_W-1:0] r_pc;
        logic [DATA_W-1:0] r_status;
        logic global_valid;
        logic [DATA_W-1:0] global_data;
    } state_s;

    state_s s_reg;
    state_s s_next;

    // marker word for one call slot; delta is the unsigned distance back
    function automatic logic [DATA_W-1:0] marker_word(input logic [1:0] slot, input logic [ADDR_W-1:0] slot_addr,
            input logic [ADDR_W-1:0] old_fp);
        logic [ADDR_W-1:0] ret;
        ret = program_counter + ADDR_W'(1) - code_base;
        case (slot)
            stack_marker_pkg::SLOT_INDEX: marker_word = index_reg;
            stack_marker_pkg::SLOT_RETURN: marker_word = DATA_W'(ret);
            stack_marker_pkg::SLOT_STATUS: marker_word = status_word;
            default: marker_word = DATA_W'(slot_addr - old_fp);
        endcase
    endfunction

    // widened sum so a wrap past the top of memory still counts as overflow
    function automatic logic past_limit(input logic [ADDR_W-1:0] from, input logic [ADDR_W:0] adv);
        past_limit = ({1'b0, from} + adv) > {1'b0, stack_limit};
    endfunction

    always_comb begin
        s_next = s_reg;
        s_next.mem_wr = 1'b0;
        s_next.mem_rd = 1'b0;
        s_next.done = 1'b0;
        s_next.overflow = 1'b0;
        s_next.restore_valid = 1'b0;
        s_next.global_valid = 1'b0;
        case (s_reg.state)
            stack_marker_pkg::ST_IDLE: begin
                if (frame_load) begin
                    // os places both pointers just past the globals
                    s_next.fp = frame_load_value;
                    s_next.smt = frame_load_value;
                    s_next.count = stack_marker_pkg::COUNT_RESET;
                end else if (procedure_call) begin
                    // flush plus marker checked up front so nothing half-completes
                    if (past_limit(s_reg.smt, (ADDR_W+1)'(s_reg.count) +
                            (ADDR_W+1)'(stack_marker_pkg::MARKER_WORDS))) begin
                        s_next.overflow = 1'b1;
                        s_next.done = 1'b1;
                    end else begin
                        s_next.step = 2'h0;
                        s_next.state = (s_reg.count != stack_marker_pkg::COUNT_RESET) ?
                            stack_marker_pkg::ST_FLUSH : stack_marker_pkg::ST_CALL;
                    end
                end else if (procedure_exit) begin
                    s_next.smt = s_reg.fp;
                    s_next.count = stack_marker_pkg::COUNT_RESET;
                    s_next.base = s_reg.fp;
                    s_next.discard = exit_discard;
                    s_next.step = 2'h0;
                    s_next.state = stack_marker_pkg::ST_EXIT_READ;
                end else if (global_rd_req) begin
                    // eight-bit offset cannot reach past the primary area
                    s_next.mem_rd = 1'b1;
                    s_next.mem_addr = data_base_pointer + ADDR_W'(global_offset);
                    s_next.state = stack_marker_pkg::ST_GLOBAL;
                end else if (push_req && s_reg.count < stack_marker_pkg::COUNT_WIDTH'(stack_marker_pkg::MAX_CACHED)) begin
                    s_next.cache[s_reg.count[1:0]] = push_data;
                    s_next.count = s_reg.count + 3'h1;
                end
            end
            stack_marker_pkg::ST_FLUSH: begin
                s_next.mem_wr = 1'b1;
                s_next.mem_addr = s_reg.smt + ADDR_W'(1);
                s_next.mem_wdata = s_reg.cache[0];
                for (int i = 0; i < stack_marker_pkg::MAX_CACHED - 1; i++) begin
                    s_next.cache[i] = s_reg.cache[i+1];
                end
                s_next.smt = s_reg.smt + ADDR_W'(1);
                s_next.count = s_reg.count - 3'h1;
                if (s_reg.count == 3'h1) begin
                    s_next.state = stack_marker_pkg::ST_CALL;
                end
            end
            stack_marker_pkg::ST_CALL: begin
                s_next.mem_wr = 1'b1;
                s_next.mem_addr = s_reg.smt + ADDR_W'(1);
                s_next.mem_wdata = marker_word(s_reg.step, s_reg.smt + ADDR_W'(1), s_reg.fp);
                s_next.smt = s_reg.smt + ADDR_W'(1);
                s_next.step = s_reg.step + 2'h1;
                if (s_reg.step == stack_marker_pkg::SLOT_DELTA) begin
                    s_next.fp = s_reg.smt + ADDR_W'(1);
                    s_next.done = 1'b1;
                    s_next.state = stack_marker_pkg::ST_IDLE;
                end
            end
            stack_marker_pkg::ST_EXIT_READ: begin
                s_next.mem_rd = 1'b1;
                s_next.mem_addr = s_reg.base - ADDR_W'(s_reg.step);
                s_next.state = stack_marker_pkg::ST_EXIT_TAKE;
            end
            stack_marker_pkg::ST_EXIT_TAKE: begin
                // walk down the marker: delta, status, return, index
                s_next.smt = s_reg.base - ADDR_W'(s_reg.step) - ADDR_W'(1);
                s_next.step = s_reg.step + 2'h1;
                s_next.state = stack_marker_pkg::ST_EXIT_READ;
                case (s_reg.step)
                    2'h0: s_next.fp = s_reg.base - ADDR_W'(mem_rdata);
                    2'h1: s_next.r_status = mem_rdata;
                    2'h2: s_next.r_pc = code_base + ADDR_W'(mem_rdata);
                    default: begin
                        s_next.r_index = mem_rdata;
                        s_next.restore_valid = 1'b1;
                        s_next.done = 1'b1;
                        // result words stay because the caller picks the discard
                        s_next.smt = s_reg.base - ADDR_W'(stack_marker_pkg::MARKER_WORDS) - s_reg.discard;
                        s_next.state = stack_marker_pkg::ST_IDLE;
                    end
                endcase
            end
            stack_marker_pkg::ST_GLOBAL: begin
                s_next.global_data = mem_rdata;
                s_next.global_valid = 1'b1;
                s_next.state = stack_marker_pkg::ST_IDLE;
            end
            default: begin
                s_next.state = stack_marker_pkg::ST_IDLE;
            end
        endcase
        s_next.top = s_next.smt + ADDR_W'(s_next.count);
        s_next.busy = (s_next.state != stack_marker_pkg::ST_IDLE);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign mem_wr = s_reg.mem_wr;
    assign mem_rd = s_reg.mem_rd;
    assign mem_addr = s_reg.mem_addr;
    assign mem_wdata = s_reg.mem_wdata;
    assign frame_pointer = s_reg.fp;
    assign memory_stack_top = s_reg.smt;
    assign cached_word_count = s_reg.count;
    assign stack_top = s_reg.top;
    assign busy = s_reg.busy;
    assign done = s_reg.done;
    assign overflow_int = s_reg.overflow;
    assign restore_valid = s_reg.restore_valid;
    assign restored_index = s_reg.r_index;
    assign restored_pc = s_reg.r_pc;
    assign restored_status = s_reg.r_status;
    assign global_valid = s_reg.global_valid;
    assign global_data = s_reg.global_data;

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    logic call_go;
    assign call_go = !s_reg.busy && !frame_load && procedure_call;

    a_global_direct: assert property (!s_reg.busy && !frame_load && !procedure_call && !procedure_exit
        && global_rd_req |=> mem_rd && mem_addr == $past(data_base_pointer) + ADDR_W'($past(global_offset)))
        else $error("global read address wrong");
    a_marker_index: assert property (s_reg.state == stack_marker_pkg::ST_CALL && s_reg.step == 2'h0
        |=> mem_wr && mem_wdata == $past(index_reg))
        else $error("first marker word not index");
    a_marker_return: assert property (s_reg.state == stack_marker_pkg::ST_CALL && s_reg.step == 2'h1
        |=> mem_wdata == DATA_W'($past(program_counter) + ADDR_W'(1) - $past(code_base)))
        else $error("return word wrong");
    a_marker_status: assert property (s_reg.state == stack_marker_pkg::ST_CALL && s_reg.step == 2'h2
        |=> mem_wdata == $past(status_word))
        else $error("status word wrong");
    a_call_length: assert property (call_go && s_reg.count == 3'h0
        && !past_limit(s_reg.smt, (ADDR_W+1)'(stack_marker_pkg::MARKER_WORDS))
        |=> !mem_wr ##1 mem_wr [*4] ##1 !mem_wr && !busy)
        else $error("marker not four words");
    a_frame_link: assert property (s_reg.state == stack_marker_pkg::ST_CALL && s_reg.step == 2'h3
        |=> frame_pointer == mem_addr && mem_wdata == DATA_W'(mem_addr - $past(s_reg.fp)))
        else $error("frame link wrong");
    a_exit_top: assert property (!s_reg.busy && !frame_load && !procedure_call && procedure_exit
        |=> memory_stack_top == $past(s_reg.fp) && cached_word_count == 3'h0 ##1 mem_addr == $past(frame_pointer, 2))
        else $error("exit top not frame");
    a_exit_unwind: assert property (!s_reg.busy && !frame_load && !procedure_call && procedure_exit
        |-> ##9 restore_valid && memory_stack_top == $past(s_reg.fp, 9) - ADDR_W'(4) - $past(exit_discard, 9))
        else $error("exit discard wrong");
    a_overflow: assert property (call_go
        && past_limit(s_reg.smt, (ADDR_W+1)'(s_reg.count) + (ADDR_W+1)'(stack_marker_pkg::MARKER_WORDS))
        |=> overflow_int && !busy && $stable(memory_stack_top))
        else $error("overflow not raised");
    a_top_sum: assert property (stack_top == memory_stack_top + ADDR_W'(cached_word_count)
        && cached_word_count <= 3'h4)
        else $error("stack top sum wrong");
    // flush keeps cache order so memory matches the top-of-stack view
    a_flush_order: assert property (s_reg.state == stack_marker_pkg::ST_FLUSH
        |=> mem_wr && mem_addr == $past(s_reg.smt) + ADDR_W'(1) && mem_wdata == $past(s_reg.cache[0]))
        else $error("flush word out of order");
    a_flush_count: assert property (s_reg.state == stack_marker_pkg::ST_FLUSH && s_reg.count == 3'h1
        |=> s_reg.state == stack_marker_pkg::ST_CALL && cached_word_count == 3'h0)
        else $error("flush did not empty cache");
    // unwind reads the marker back in reverse order
    a_exit_frame: assert property (s_reg.state == stack_marker_pkg::ST_EXIT_TAKE && s_reg.step == 2'h0
        |=> frame_pointer == $past(s_reg.base) - ADDR_W'($past(mem_rdata)))
        else $error("frame not restored by delta");
    a_exit_status: assert property (s_reg.state == stack_marker_pkg::ST_EXIT_TAKE && s_reg.step == 2'h1
        |=> restored_status == $past(mem_rdata))
        else $error("status not restored");
    a_exit_return: assert property (s_reg.state == stack_marker_pkg::ST_EXIT_TAKE && s_reg.step == 2'h2
        |=> restored_pc == $past(code_base) + ADDR_W'($past(mem_rdata)))
        else $error("return position not restored");
    a_global_data: assert property (s_reg.state == stack_marker_pkg::ST_GLOBAL
        |=> global_valid && global_data == $past(mem_rdata))
        else $error("global data not passed");
    a_push_full: assert property (!s_reg.busy && !frame_load && !procedure_call && !procedure_exit
        && !global_rd_req && push_req && cached_word_count == 3'h4 |=> cached_word_count == 3'h4)
        else $error("push into full cache");
    c_call_flush: cover property (s_reg.state == stack_marker_pkg::ST_FLUSH ##1 s_reg.state == stack_marker_pkg::ST_CALL);
    c_exit_done: cover property (restore_valid);
    c_overflow: cover property (overflow_int);
    c_empty_call: cover property (call_go && s_reg.count == 3'h0);
    c_push_full: cover property (!s_reg.busy && push_req && cached_word_count == 3'h4);
endmodule
`default_nettype wire

// >>> verification/stack_memory_model.sv
`timescale 1ns/10ps
`default_nettype none
module stack_memory_model (
    input wire logic clk,
    input wire logic mem_wr,
    input wire logic mem_rd,
    input wire logic [stack_marker_pkg::ADDR_WIDTH-1:0] mem_addr,
    input wire logic [stack_marker_pkg::DATA_WIDTH-1:0] mem_wdata,
    output logic [stack_marker_pkg::DATA_WIDTH-1:0] mem_rdata
);
    logic [stack_marker_pkg::DATA_WIDTH-1:0] words [0:65535];
    logic [stack_marker_pkg::DATA_WIDTH-1:0] last_reg = 16'h0;
    // outside a read the lines show the inverse, so a late sample never passes
    always_comb begin
        mem_rdata = mem_rd ? words[mem_addr] : ~last_reg;
    end
    always @(posedge clk) begin
        if (mem_rd) last_reg <= words[mem_addr];
        if (mem_wr) words[mem_addr] <= mem_wdata;
    end
endmodule
`default_nettype wire

// >>> verification/procedure_stack_marker_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module procedure_stack_marker_tb_top;
    logic clk = 1'b0, srst = 1'b1, frame_load = 1'b0, push_req = 1'b0;
    logic procedure_call = 1'b0, procedure_exit = 1'b0, global_rd_req = 1'b0;
    logic [15:0] frame_load_value = 16'h0, data_base_pointer = 16'h0040, stack_limit = 16'h0fff;
    logic [15:0] code_base = 16'h0400, program_counter = 16'h0450, index_reg = 16'h1234;
    logic [15:0] status_word = 16'h8005, push_data = 16'h0, exit_discard = 16'h0, mem_rdata;
    logic [7:0] global_offset = 8'h0;
    logic mem_wr, mem_rd, busy, done, overflow_int, restore_valid, global_valid;
    logic [15:0] mem_addr, mem_wdata, frame_pointer, memory_stack_top, stack_top;
    logic [15:0] restored_index, restored_pc, restored_status, global_data, first_rd;
    logic [2:0] cached_word_count;
    logic saw_ovf;
    int failures = 0, compares = 0, wr_count;

    always #20 clk = ~clk;

    procedure_stack_marker uut (.clk(clk), .srst(srst), .frame_load(frame_load),
        .frame_load_value(frame_load_value), .data_base_pointer(data_base_pointer),
        .stack_limit(stack_limit), .code_base(code_base), .program_counter(program_counter),
        .index_reg(index_reg), .status_word(status_word), .push_req(push_req), .push_data(push_data),
        .procedure_call(procedure_call), .procedure_exit(procedure_exit), .exit_discard(exit_discard),
        .global_rd_req(global_rd_req), .global_offset(global_offset), .mem_rdata(mem_rdata),
        .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .frame_pointer(frame_pointer), .memory_stack_top(memory_stack_top),
        .cached_word_count(cached_word_count), .stack_top(stack_top), .busy(busy), .done(done),
        .overflow_int(overflow_int), .restore_valid(restore_valid), .restored_index(restored_index),
        .restored_pc(restored_pc), .restored_status(restored_status), .global_valid(global_valid),
        .global_data(global_data));

    stack_memory_model mem_model (.clk(clk), .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic pulse(ref logic sig);
        sig = 1'b1;
        @(posedge clk); #1;
        sig = 1'b0;
    endtask

    // watches the operation cycle by cycle, bounded
    task automatic run_op();
        int i;
        wr_count = 0;
        first_rd = 16'hffff;
        saw_ovf = 1'b0;
        for (i = 0; i < 40; i++) begin
            if (mem_wr === 1'b1) wr_count++;
            if (mem_rd === 1'b1 && first_rd === 16'hffff) first_rd = mem_addr;
            if (overflow_int === 1'b1) saw_ovf = 1'b1;
            if (done === 1'b1 || global_valid === 1'b1) return;
            @(posedge clk); #1;
        end
        failures++;
        $display("[ERR] %0t operation never completed", $time);
        report_and_stop();
    endtask

    task automatic test_call();
        frame_load_value = 16'h0100;
        pulse(frame_load);
        push_req = 1'b1;
        push_data = 16'h0031;
        @(posedge clk); #1;
        push_data = 16'h000c;
        @(posedge clk); #1;
        push_req = 1'b0;
        chk(16'(cached_word_count), 16'h0002);
        chk(stack_top, 16'h0102);
        pulse(procedure_call);
        run_op();
        // the last marker word lands in memory one edge after done
        @(posedge clk); #1;
        chk(16'(wr_count), 16'h0006);
        chk(mem_model.words[16'h0101], 16'h0031);
        chk(mem_model.words[16'h0102], 16'h000c);
        chk(mem_model.words[16'h0103], 16'h1234);
        chk(mem_model.words[16'h0104], 16'h0051);
        chk(mem_model.words[16'h0105], 16'h8005);
        chk(mem_model.words[16'h0106], 16'h0006);
        chk(frame_pointer, 16'h0106);
        chk(16'(cached_word_count), 16'h0000);
        chk(stack_top, 16'h0106);
    endtask

    task automatic test_exit();
        index_reg = 16'h0;
        status_word = 16'h0;
        exit_discard = 16'h0002;
        pulse(procedure_exit);
        run_op();
        chk(first_rd, 16'h0106);
        chk(frame_pointer, 16'h0100);
        chk(16'(restore_valid), 16'h0001);
        chk(restored_status, 16'h8005);
        chk(restored_pc, 16'h0451);
        chk(restored_index, 16'h1234);
        chk(memory_stack_top, 16'h0100);
    endtask

    // limit one word short of the marker
    task automatic test_overflow();
        stack_limit = 16'h0103;
        pulse(procedure_call);
        run_op();
        chk(16'(saw_ovf), 16'h0001);
        chk(16'(wr_count), 16'h0000);
        chk(frame_pointer, 16'h0100);
        chk(memory_stack_top, 16'h0100);
    endtask

    task automatic test_global();
        mem_model.words[16'h013f] = 16'hbeef;
        global_offset = 8'hff;
        pulse(global_rd_req);
        run_op();
        chk(first_rd, 16'h013f);
        chk(global_data, 16'hbeef);
    endtask

    // empty-cache call with a push refused while busy, then a chained exit
    task automatic test_empty_call();
        stack_limit = 16'h0fff;
        index_reg = 16'h0777;
        exit_discard = 16'h0000;
        pulse(procedure_call);
        chk(16'(busy), 16'h0001);
        push_req = 1'b1;
        @(posedge clk); #1;
        push_req = 1'b0;
        run_op();
        chk(16'(wr_count), 16'h0004);
        chk(16'(busy), 16'h0000);
        chk(16'(cached_word_count), 16'h0000);
        chk(frame_pointer, 16'h0104);
        @(posedge clk); #1;
        chk(mem_model.words[16'h0101], 16'h0777);
        chk(mem_model.words[16'h0104], 16'h0004);
        pulse(procedure_exit);
        run_op();
        chk(frame_pointer, 16'h0100);
        chk(restored_index, 16'h0777);
        chk(stack_top, 16'h0100);
    endtask

    // fifth push meets a full cache and is dropped; the call then flushes four
    task automatic test_push_full();
        push_req = 1'b1;
        repeat (5) begin
            @(posedge clk); #1;
        end
        push_req = 1'b0;
        chk(16'(cached_word_count), 16'h0004);
        chk(stack_top, 16'h0104);
        pulse(procedure_call);
        run_op();
        chk(16'(wr_count), 16'h0008);
        chk(mem_model.words[16'h0101], 16'h000c);
        chk(frame_pointer, 16'h0108);
        chk(16'(cached_word_count), 16'h0000);
    endtask

    initial begin
        repeat (2) @(posedge clk);
        #1;
        srst = 1'b0;
        test_call();
        test_exit();
        test_overflow();
        test_global();
        test_empty_call();
        test_push_full();
        report_and_stop();
    end
endmodule
`default_nettype wire
